// ---- hdl/atd_taskfile_decode.v ----
// Task-file address decoder, byte-lane steering and data-register stream
`timescale 1ns/1ps
`include "atd_defs.vh"

module atd_taskfile_decode (
    input wire core_clk, // 100 MHz clock
    input wire rst_n, // Synchronous reset
    input wire clk_en, // Freezes all state when low
    input wire [1:0] cfg_index, // Mapping selected by configuration
    input wire reg_n, // Register-space select
    input wire ce1_n, // Even-lane card enable
    input wire ce2_n, // Odd-lane card enable
    input wire oe_n, // Memory read strobe, also mode strap
    input wire we_n, // Memory write strobe
    input wire iord_n, // I/O read strobe
    input wire iowr_n, // I/O write strobe
    input wire [10:0] addr, // Host address
    input wire [15:0] d_in, // Host data bus input
    output reg [15:0] d_out, // Host data bus output
    output reg d_oe_lo, // Drive D7-D0
    output reg d_oe_hi, // Drive D15-D8
    output reg iois16_n, // 16-bit I/O port indication
    output reg wait_n, // Stretches the cycle on stall
    output reg ide_mode, // Direct IDE mode strapped
    output reg [3:0] tf_sel, // Task-file register offset
    output reg tf_rd, // Task-file read done pulse
    output reg tf_wr, // Task-file write pulse
    output reg [7:0] tf_wdata, // Task-file write byte
    input wire [7:0] tf_rdata, // Task-file read byte
    input wire [15:0] rd_data, // Sector buffer head word
    input wire rd_valid, // Sector buffer word available
    output reg rd_ready, // Sector buffer word consumed
    output reg [15:0] wr_data, // Word toward sector buffer
    output reg wr_valid, // Word toward sector buffer valid
    input wire wr_ready // Sector buffer accepts word
);

    localparam ACT_NONE = 5'h01;
    localparam ACT_WORD = 5'h02;
    localparam ACT_SEQ = 5'h04;
    localparam ACT_ODD = 5'h08;
    localparam ACT_TF = 5'h10;

    // Folds the duplicate error offset onto the primary one
    function [3:0] tf_code;
        input [3:0] off;
        begin
            if (off == `ATD_OFF_DUP_ERR)
                tf_code = `ATD_OFF_ERR;
            else
                tf_code = off;
        end
    endfunction

    function is_gap;
        input [3:0] off;
        begin
            is_gap = (off == `ATD_OFF_GAP_A) || (off == `ATD_OFF_GAP_B) ||
                (off == `ATD_OFF_GAP_C);
        end
    endfunction

    // Returns {valid, offset}
    function [4:0] decode_off;
        input [10:0] a;
        input regn;
        input ce1n;
        input ce2n;
        input ide;
        input mem;
        input [1:0] cfg;
        reg [5:0] base;
        reg [5:0] alt;
        begin
            decode_off = 5'h00;
            base = (cfg == `ATD_CFG_PRI) ? `ATD_PRI_BASE : `ATD_SEC_BASE;
            alt = (cfg == `ATD_CFG_PRI) ? `ATD_PRI_ALT : `ATD_SEC_ALT;
            if (ide) begin
                if (!ce1n && ce2n)
                    decode_off = {2'b10, a[2:0]};
                else if (ce1n && !ce2n && a[2:1] == `ATD_IDE_ALT_SEL)
                    decode_off = {4'b1111, a[0]};
            end else if (ce1n && ce2n) begin
                decode_off = 5'h00;
            end else if (mem) begin
                if (regn) begin
                    if (a[10])
                        decode_off = {4'b1100, a[0]};
                    else if (!is_gap(a[3:0]))
                        decode_off = {1'b1, a[3:0]};
                end
            end else if (!regn) begin
                if (cfg == `ATD_CFG_CONTIG) begin
                    if (!is_gap(a[3:0]))
                        decode_off = {1'b1, a[3:0]};
                end else if (a[9:4] == base && !a[3]) begin
                    decode_off = {2'b10, a[2:0]};
                end else if (a[9:4] == alt && a[3:1] == `ATD_ALT_SEL) begin
                    decode_off = {4'b1111, a[0]};
                end
            end
        end
    endfunction

    reg [17:0] pin_s1_reg;
    reg [17:0] pin_s2_reg;
    reg [15:0] din_s1_reg;
    reg [15:0] din_s2_reg;
    reg [1:0] strap_cnt_reg;
    reg rd_prev_reg;
    reg wr_prev_reg;
    reg [4:0] act_reg;
    reg hi_reg;
    reg [3:0] code_reg;
    reg [15:0] wdat_reg;
    reg even_done_reg;
    reg odd_done_reg;
    reg [15:0] wbuf_reg;
    reg [15:0] spare_reg;
    reg spare_valid_reg;

    wire [10:0] a_s = pin_s2_reg[10:0];
    wire iowr_s = pin_s2_reg[11];
    wire iord_s = pin_s2_reg[12];
    wire we_s = pin_s2_reg[13];
    wire oe_s = pin_s2_reg[14];
    wire ce1_s = pin_s2_reg[15];
    wire ce2_s = pin_s2_reg[16];
    wire reg_s = pin_s2_reg[17];
    wire strap_done = (strap_cnt_reg == `ATD_STRAP_WAIT);
    wire mem_mode = !ide_mode && cfg_index == `ATD_CFG_MEM;

    wire acc_rd = ide_mode ? !iord_s : (mem_mode ? (!oe_s && reg_s) : (!iord_s && !reg_s));
    wire acc_wr = ide_mode ? !iowr_s : (mem_mode ? (!we_s && reg_s) : (!iowr_s && !reg_s));
    wire [4:0] dec = decode_off(a_s, reg_s, ce1_s, ce2_s, ide_mode, mem_mode, cfg_index);
    wire dv = dec[4] && strap_done;
    wire [3:0] off = dec[3:0];
    wire is_dat = (off == `ATD_OFF_DATA) || (off == `ATD_OFF_DUP_EVEN) ||
        (off == `ATD_OFF_DUP_ODD);
    wire is_dat1 = is_dat || (off == `ATD_OFF_ERR);
    wire word_e = ide_mode ? (off == `ATD_OFF_DATA) : (!ce1_s && !ce2_s);
    wire lo_e = ide_mode ? (off != `ATD_OFF_DATA) : (!ce1_s && ce2_s);
    wire hi_e = !ide_mode && ce1_s && !ce2_s && (mem_mode || is_dat1);

    reg [4:0] act_c;
    reg hi_c;
    reg [3:0] code_c;
    reg [3:0] odd_off;

    always @* begin
        act_c = ACT_NONE;
        hi_c = 1'b0;
        code_c = off;
        odd_off = off | 4'h1;
        if (dv && (acc_rd || acc_wr)) begin
            if (word_e) begin
                if (is_dat1) begin
                    act_c = ACT_WORD;
                end else begin
                    act_c = ACT_TF;
                    code_c = tf_code(off);
                end
            end else if (lo_e) begin
                if (off == `ATD_OFF_DATA || off == `ATD_OFF_DUP_EVEN) begin
                    act_c = ACT_SEQ;
                end else if (off == `ATD_OFF_DUP_ODD) begin
                    act_c = ACT_ODD;
                end else begin
                    act_c = ACT_TF;
                    code_c = tf_code(off);
                end
            end else if (hi_e) begin
                hi_c = 1'b1;
                if (odd_off == `ATD_OFF_DUP_ODD) begin
                    act_c = ACT_ODD;
                end else begin
                    act_c = ACT_TF;
                    code_c = tf_code(odd_off);
                end
            end
        end
    end

    wire act_dat = (act_c == ACT_WORD) || (act_c == ACT_SEQ) || (act_c == ACT_ODD);
    wire rd_end = rd_prev_reg && !acc_rd;
    wire wr_end = wr_prev_reg && !acc_wr;
    wire [7:0] wbyte = hi_reg ? wdat_reg[15:8] : wdat_reg[7:0];

    reg ev_n;
    reg od_n;
    reg adv;
    reg [15:0] wb_n;

    // Shared position for every alias of the data register
    always @* begin
        ev_n = even_done_reg;
        od_n = odd_done_reg;
        wb_n = wbuf_reg;
        adv = 1'b0;
        if (rd_end || wr_end) begin
            case (act_reg)
                ACT_WORD: begin
                    adv = 1'b1;
                    wb_n = wdat_reg;
                end
                ACT_SEQ: begin
                    if (!even_done_reg) begin
                        ev_n = 1'b1;
                        wb_n[7:0] = wbyte;
                    end else begin
                        od_n = 1'b1;
                        wb_n[15:8] = wbyte;
                    end
                end
                ACT_ODD: begin
                    od_n = 1'b1;
                    wb_n[15:8] = wbyte;
                end
                default: begin
                    adv = 1'b0;
                end
            endcase
        end
        if (ev_n && od_n)
            adv = 1'b1;
        if (adv) begin
            ev_n = 1'b0;
            od_n = 1'b0;
        end
    end

    wire pop_out = wr_valid && wr_ready;
    wire push = adv && wr_end && !spare_valid_reg;

    reg [15:0] rdout_c;
    reg [7:0] rbyte;

    always @* begin
        rbyte = tf_rdata;
        if (act_c == ACT_SEQ)
            rbyte = even_done_reg ? rd_data[15:8] : rd_data[7:0];
        else if (act_c == ACT_ODD)
            rbyte = rd_data[15:8];
        if (act_c == ACT_WORD)
            rdout_c = rd_data;
        else if (hi_c)
            rdout_c = {rbyte, 8'h00};
        else
            rdout_c = {8'h00, rbyte};
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            pin_s1_reg <= `ATD_PIN_RST;
            pin_s2_reg <= `ATD_PIN_RST;
            din_s1_reg <= `ATD_DAT_RST;
            din_s2_reg <= `ATD_DAT_RST;
            strap_cnt_reg <= 2'h0;
            ide_mode <= 1'b0;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            act_reg <= ACT_NONE;
            hi_reg <= 1'b0;
            code_reg <= 4'h0;
            wdat_reg <= `ATD_DAT_RST;
            even_done_reg <= 1'b0;
            odd_done_reg <= 1'b0;
            wbuf_reg <= `ATD_DAT_RST;
            d_out <= `ATD_DAT_RST;
            d_oe_lo <= 1'b0;
            d_oe_hi <= 1'b0;
            iois16_n <= 1'b1;
            wait_n <= 1'b1;
            tf_sel <= 4'h0;
            tf_rd <= 1'b0;
            tf_wr <= 1'b0;
            tf_wdata <= 8'h00;
            rd_ready <= 1'b0;
        end else if (clk_en) begin
            pin_s1_reg <= {reg_n, ce2_n, ce1_n, oe_n, we_n, iord_n, iowr_n, addr};
            pin_s2_reg <= pin_s1_reg;
            din_s1_reg <= d_in;
            din_s2_reg <= din_s1_reg;
            // Pins reach the second stage two edges late: strap read on the third
            if (!strap_done) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
                if (strap_cnt_reg == `ATD_STRAP_WAIT - 2'h1)
                    ide_mode <= !oe_s;
            end
            rd_prev_reg <= acc_rd && act_c != ACT_NONE;
            wr_prev_reg <= acc_wr && act_c != ACT_NONE;
            if (acc_rd || acc_wr) begin
                act_reg <= act_c;
                hi_reg <= hi_c;
                code_reg <= code_c;
                tf_sel <= code_c;
            end
            if (acc_wr)
                wdat_reg <= din_s2_reg;
            even_done_reg <= ev_n;
            odd_done_reg <= od_n;
            wbuf_reg <= wb_n;
            d_out <= rdout_c;
            d_oe_lo <= acc_rd && act_c != ACT_NONE && (!hi_c || act_c == ACT_WORD);
            d_oe_hi <= acc_rd && (hi_c || act_c == ACT_WORD);
            iois16_n <= !(dv && !mem_mode && is_dat1);
            wait_n <= !(act_dat && ((acc_wr && spare_valid_reg) || (acc_rd && !rd_valid)));
            tf_rd <= rd_end && act_reg == ACT_TF;
            tf_wr <= wr_end && act_reg == ACT_TF && code_reg != `ATD_OFF_DRVADDR;
            if (wr_end && act_reg == ACT_TF)
                tf_wdata <= wbyte;
            rd_ready <= adv && rd_end && rd_valid;
        end
    end

    // Two-entry write buffer: head is the output, spare absorbs a stall
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_data <= `ATD_DAT_RST;
            wr_valid <= 1'b0;
            spare_reg <= `ATD_DAT_RST;
            spare_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (pop_out) begin
                if (spare_valid_reg) begin
                    wr_data <= spare_reg;
                    spare_valid_reg <= 1'b0;
                end else begin
                    wr_valid <= 1'b0;
                end
            end
            if (push) begin
                if (!wr_valid || (pop_out && !spare_valid_reg)) begin
                    wr_data <= wb_n;
                    wr_valid <= 1'b1;
                end else begin
                    spare_reg <= wb_n;
                    spare_valid_reg <= 1'b1;
                end
            end
        end
    end

endmodule // atd_taskfile_decode

// ---- hdl/atd_defs.vh ----
// Constants for the task-file address and byte-lane decoder
// Operation
// - Primary/secondary I/O selects offsets 0-7, 6/7 alternates
// - Both card enables low: one 16-bit data word
// - Byte pair at offset 0: even then odd
// - Upper-lane byte at offset 0 reaches error/feature
// - Offsets 8, 9, D duplicate data and error/feature
// - Byte 9 then 8 gives odd then even
// - Byte accesses at 8/0, or 8 then 9, step bytes
// - Word accesses at 8, 9, 0 step words
// - Byte at offset 9 carries only odd byte
// - Memory mode decodes A3-A0 below 400h
// - Window 400h-7FFh maps even to 8, odd to 9
// - Memory window is sequential, never random access
// - Contiguous I/O: 0-7, duplicates, E and F
// - Direct IDE decodes card enables with A2-A0
// - Odd registers reachable on upper lanes below
// - Data register is 16 bits to buffer
// - Word access at offset 1 hits data register
// - Duplicates 8 and 9 accept every byte/word combination
// - Direct IDE only with output enable grounded
// - Config index picks memory, contiguous, primary, secondary
`ifndef ATD_DEFS_VH
`define ATD_DEFS_VH

`define ATD_CFG_MEM 2'h0
`define ATD_CFG_CONTIG 2'h1
`define ATD_CFG_PRI 2'h2
`define ATD_CFG_SEC 2'h3

`define ATD_PRI_BASE 6'h1F
`define ATD_SEC_BASE 6'h17
`define ATD_PRI_ALT 6'h3F
`define ATD_SEC_ALT 6'h37
`define ATD_IDE_ALT_SEL 2'h3
`define ATD_ALT_SEL 3'h3

`define ATD_OFF_DATA 4'h0
`define ATD_OFF_ERR 4'h1
`define ATD_OFF_SECCNT 4'h2
`define ATD_OFF_SECNUM 4'h3
`define ATD_OFF_CYLLO 4'h4
`define ATD_OFF_CYLHI 4'h5
`define ATD_OFF_DRVHEAD 4'h6
`define ATD_OFF_STATUS 4'h7
`define ATD_OFF_DUP_EVEN 4'h8
`define ATD_OFF_DUP_ODD 4'h9
`define ATD_OFF_GAP_A 4'hA
`define ATD_OFF_GAP_B 4'hB
`define ATD_OFF_GAP_C 4'hC
`define ATD_OFF_DUP_ERR 4'hD
`define ATD_OFF_ALT 4'hE
`define ATD_OFF_DRVADDR 4'hF

`define ATD_PIN_RST 18'h3FFFF
`define ATD_DAT_RST 16'h0000
`define ATD_STRAP_WAIT 2'h3

`endif

// ---- verif/atd_sector_model.sv ----
// Sector buffer and task-file stand-in for the decoder
`timescale 1ns/1ps
module atd_sector_model (
    input wire core_clk, // Clock
    input wire rst_n, // Reset
    input wire stall, // Write side not ready
    input wire [3:0] tf_sel, // Register offset
    input wire tf_wr, // Register write
    input wire [7:0] tf_wdata, // Register byte
    output wire [7:0] tf_rdata, // Register read byte
    output wire [15:0] rd_data, // Head word
    output wire rd_valid, // Head present
    input wire rd_ready, // Head consumed
    input wire [15:0] wr_data, // Pushed word
    input wire wr_valid, // Pushed valid
    output wire wr_ready // Accepts word
);
    logic [7:0] pop_reg;
    logic [11:0] tf_last;
    logic [15:0] got[0:7];
    int wr_cnt;
    assign tf_rdata = {4'hC, tf_sel};
    assign rd_data = {pop_reg ^ 8'h5A, pop_reg};
    assign rd_valid = 1'b1;
    assign wr_ready = !stall;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pop_reg <= 8'h00;
            wr_cnt <= 0;
        end else begin
            if (rd_ready)
                pop_reg <= pop_reg + 8'h01;
            if (wr_valid && wr_ready) begin
                got[wr_cnt[2:0]] <= wr_data;
                wr_cnt <= wr_cnt + 1;
            end
            if (tf_wr)
                tf_last <= {tf_sel, tf_wdata};
        end
    end
endmodule // atd_sector_model

// ---- verif/atd_taskfile_decode_assertions.sv ----
// Port checks for the task-file decoder
`timescale 1ns/1ps
module atd_taskfile_decode_assertions (
    input wire core_clk, // Clock
    input wire rst_n, // Reset
    input wire oe_n, // Memory read
    input wire iord_n, // I/O read
    input wire [10:0] addr, // Address
    input logic d_oe_lo, // Low lane drive
    input logic d_oe_hi, // High lane drive
    input logic ide_mode, // Strap
    input logic [3:0] tf_sel, // Offset
    input logic tf_rd, // Read pulse
    input logic tf_wr, // Write pulse
    input logic rd_ready, // Pop
    input logic [15:0] wr_data, // Push word
    input logic wr_valid, // Push valid
    input wire wr_ready // Push ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    rd_drive_only_a: assert property ((d_oe_lo || d_oe_hi) |->
        (!$past(iord_n, 3) || !$past(oe_n, 3))) else $error("drive without read");
    gap_quiet_a: assert property ((d_oe_lo || d_oe_hi) && !ide_mode && !$past(addr[10], 3)
        |-> !($past(addr[3:0], 3) inside {4'hA, 4'hB, 4'hC})) else $error("gap driven");
    tf_wr_sel_a: assert property (tf_wr |-> tf_sel inside {[4'h1:4'h7], 4'hE})
        else $error("bad write offset");
    pop_pulse_a: assert property (rd_ready |-> $past(d_oe_lo || d_oe_hi) ##1 !rd_ready)
        else $error("bad pop");
    tf_rd_excl_a: assert property (tf_rd |-> !rd_ready && $past(d_oe_lo || d_oe_hi))
        else $error("bad register read");
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("push lost");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !d_oe_lo && !d_oe_hi
        && !rd_ready && !wr_valid && !tf_wr && !ide_mode) else $error("reset not quiet");
    ide_strap_a: assert property ($rose(ide_mode) |-> !$past(oe_n, 2) || !$past(oe_n, 3))
        else $error("strap wrong");
    cover property (rd_ready);
    cover property (tf_wr && tf_sel == 4'h7);
    cover property (wr_valid && !wr_ready);
endmodule // atd_taskfile_decode_assertions
bind atd_taskfile_decode atd_taskfile_decode_assertions u_chk (.core_clk, .rst_n, .oe_n,
    .iord_n, .addr, .d_oe_lo, .d_oe_hi, .ide_mode, .tf_sel, .tf_rd, .tf_wr, .rd_ready,
    .wr_data, .wr_valid, .wr_ready);

// ---- verif/tb.sv ----
// Self-checking bench for the task-file decoder
`timescale 1ns/1ps
module tb;
    logic core_clk, rst_n, stall, strap, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n;
    logic d_oe_lo, d_oe_hi, iois16_n, wait_n, ide_mode, tf_rd, tf_wr, rd_valid, rd_ready;
    logic wr_valid, wr_ready, saw_wait, io16;
    logic [1:0] cfg_index, ro;
    logic [3:0] tf_sel;
    logic [7:0] tf_wdata, tf_rdata, k;
    logic [10:0] addr;
    logic [15:0] d_in, d_out, rd_data, wr_data, r, e;
    int bad_count, checked, i;
    atd_taskfile_decode u_dut (.core_clk, .rst_n, .clk_en(1'b1), .cfg_index, .reg_n, .ce1_n,
        .ce2_n, .oe_n, .we_n, .iord_n, .iowr_n, .addr, .d_in, .d_out, .d_oe_lo, .d_oe_hi,
        .iois16_n, .wait_n, .ide_mode, .tf_sel, .tf_rd, .tf_wr, .tf_wdata, .tf_rdata,
        .rd_data, .rd_valid, .rd_ready, .wr_data, .wr_valid, .wr_ready);
    atd_sector_model u_mdl (.core_clk, .rst_n, .stall, .tf_sel, .tf_wr, .tf_wdata,
        .tf_rdata, .rd_data, .rd_valid, .rd_ready, .wr_data, .wr_valid, .wr_ready);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic [15:0] wd(input [7:0] n);
        return {n ^ 8'h5A, n};
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task do_reset(input logic s);
        strap = s;
        rst_n <= 1'b0;
        oe_n <= s;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        k = 8'h00;
    endtask
    // One host cycle; strobe held until wait_n lets go
    task acc(input logic w, io, rg, c1, c2, input logic [10:0] a, input logic [15:0] wv);
        int n;
        @(posedge core_clk);
        reg_n <= rg;
        ce1_n <= c1;
        ce2_n <= c2;
        addr <= a;
        d_in <= wv;
        @(posedge core_clk);
        if (io && w) iowr_n <= 1'b0;
        else if (io) iord_n <= 1'b0;
        else if (w) we_n <= 1'b0;
        else oe_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        n = 0;
        while (wait_n !== 1'b1 && n < 300) begin
            saw_wait = 1'b1;
            n++;
            @(posedge core_clk);
            #1;
        end
        if (n == 300) chk({15'h0000, wait_n}, 16'h0001);
        r = d_out;
        ro = {d_oe_hi, d_oe_lo};
        io16 = iois16_n;
        @(posedge core_clk);
        iord_n <= 1'b1;
        iowr_n <= 1'b1;
        we_n <= 1'b1;
        oe_n <= strap;
        repeat (5) @(posedge core_clk);
        ce1_n <= 1'b1;
        ce2_n <= 1'b1;
    endtask
    initial begin
        {reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n} = 7'h7F;
        {rst_n, stall, saw_wait, bad_count, checked} = 0;
        cfg_index = 2'h1;
        addr = 11'h000;
        d_in = 16'h0000;
        do_reset(1'b1);
        chk({15'h0000, ide_mode}, 16'h0000);
        for (i = 0; i < 4; i++) begin
            acc(0, 1, 0, 0, 0, {7'h00, i[1] ? 4'(i - 2) : 4'(i + 8)}, 16'h0000);
            chk(r, wd(k));
            chk({15'h0000, io16}, 16'h0000);
            k++;
        end
        $display("test words done");
        for (i = 0; i < 3; i++) begin
            e = wd(k);
            acc(0, 1, 0, 0, 1, i == 1 ? 11'h009 : i == 2 ? 11'h008 : 11'h000, 16'h0000);
            chk({8'h00, r[7:0]}, {8'h00, i == 1 ? e[15:8] : e[7:0]});
            acc(0, 1, 0, 0, 1, i == 1 ? 11'h008 : i == 2 ? 11'h009 : 11'h000, 16'h0000);
            chk({8'h00, r[7:0]}, {8'h00, i == 1 ? e[7:0] : e[15:8]});
            k++;
        end
        acc(0, 1, 0, 1, 0, 11'h000, 16'h0000);
        chk({r[15:8], 6'h00, ro}, 16'hC102);
        for (i = 10; i < 13; i++) begin
            acc(0, 1, 0, 0, 1, 11'(i), 16'h0000);
            chk({14'h0000, ro}, 16'h0000);
        end
        $display("test bytes done");
        cfg_index <= 2'h2;
        for (i = 2; i < 8; i++) begin
            acc(1, 1, 0, 0, 1, 11'h1F0 + 11'(i), 16'h0030 + 16'(i));
            chk({4'h0, u_mdl.tf_last}, {4'h0, 4'(i), 8'h30 + 8'(i)});
            acc(0, 1, 0, 0, 1, 11'h1F0 + 11'(i), 16'h0000);
            chk({8'h00, r[7:0]}, {8'h00, 4'hC, 4'(i)});
            chk({15'h0000, io16}, 16'h0001);
        end
        acc(0, 1, 0, 0, 1, 11'h3F6, 16'h0000);
        chk({8'h00, r[7:0]}, 16'h00CE);
        cfg_index <= 2'h3;
        acc(0, 1, 0, 0, 1, 11'h377, 16'h0000);
        chk({8'h00, r[7:0]}, 16'h00CF);
        acc(0, 1, 0, 0, 1, 11'h1F6, 16'h0000);
        chk({14'h0000, ro}, 16'h0000);
        cfg_index <= 2'h1;
        acc(1, 1, 0, 0, 1, 11'h00F, 16'h0099);
        chk({4'h0, u_mdl.tf_last}, 16'h0737);
        $display("test registers done");
        cfg_index <= 2'h0;
        e = wd(k);
        acc(0, 0, 1, 0, 1, 11'h404, 16'h0000);
        chk({8'h00, r[7:0]}, {8'h00, e[7:0]});
        acc(0, 0, 1, 0, 1, 11'h7FF, 16'h0000);
        chk({8'h00, r[7:0]}, {8'h00, e[15:8]});
        k++;
        acc(0, 0, 1, 0, 0, 11'h3F8, 16'h0000);
        chk(r, wd(k));
        $display("test memory done");
        cfg_index <= 2'h1;
        stall <= 1'b1;
        fork
            begin
                repeat (80) @(posedge core_clk);
                stall <= 1'b0;
            end
        join_none
        acc(1, 1, 0, 0, 1, 11'h000, 16'h0011);
        acc(1, 1, 0, 0, 1, 11'h000, 16'h0022);
        for (i = 0; i < 3; i++)
            acc(1, 1, 0, 0, 0, 11'h008, 16'hB000 + 16'(i));
        repeat (20) @(posedge core_clk);
        chk(16'(u_mdl.wr_cnt), 16'h0004);
        chk(u_mdl.got[0], 16'h2211);
        for (i = 1; i < 4; i++)
            chk(u_mdl.got[i], 16'hB000 + 16'(i - 1));
        chk({15'h0000, saw_wait}, 16'h0001);
        $display("test writes done");
        do_reset(1'b0);
        chk({15'h0000, ide_mode}, 16'h0001);
        acc(0, 1, 0, 0, 1, 11'h000, 16'h0000);
        chk(r, wd(k));
        acc(0, 1, 0, 1, 0, 11'h006, 16'h0000);
        chk({8'h00, r[7:0]}, 16'h00CE);
        $display("test direct mode done");
        conclude;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        conclude;
    end
endmodule // tb
